// [inc/fpdc_pkg.sv]
// constants and carrier types for the flash program download control block
`default_nettype none
package fpdc_pkg;
  // on-chip routine image and download window
  localparam int unsigned ROUTINE_BYTES   = 2048;
  localparam int unsigned WORD_BYTES      = 4;
  localparam int unsigned ROUTINE_WORDS   = ROUTINE_BYTES / WORD_BYTES;
  localparam int unsigned WORD_CNT_W      = 10;
  localparam logic [31:0] RAM_BASE_ADDR   = 32'hffff6000;
  localparam logic [31:0] WINDOW_STEP     = 32'h00000800;
  // key code and destination select
  localparam logic [7:0]  KEY_DOWNLOAD    = 8'ha5;
  localparam logic [7:0]  KEY_RESET       = 8'h00;
  localparam logic [6:0]  DEST_MAX_VALID  = 7'h05;
  localparam int unsigned DEST_ERR_BIT    = 7;
  localparam logic [7:0]  DEST_RESET      = 8'h00;
  // result byte field positions
  localparam int unsigned RES_SEL_ERR_BIT = 2;
  localparam int unsigned RES_KEY_ERR_BIT = 1;
  localparam int unsigned RES_FAIL_BIT    = 0;
  // cpu general registers used for parameter passing
  localparam int unsigned GPR_COUNT       = 16;
  localparam logic [3:0]  GPR_RESULT      = 4'h0;
  localparam logic [3:0]  GPR_PARAM_A     = 4'h4;
  localparam logic [3:0]  GPR_PARAM_B     = 4'h5;
  // byte enables, big-endian: first byte of a word sits in the top lane
  localparam logic [3:0]  BE_WORD         = 4'hf;
  localparam logic [3:0]  BE_FIRST_BYTE   = 4'h8;
  localparam int unsigned FIFO_DEPTH      = 32;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_COPY   = 3'b010,
    ST_RESULT = 3'b011,
    ST_DONE   = 3'b100
  } fpdc_state_t;

  typedef struct packed
  {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  byte_en;
  } fpdc_ram_req_t;
endpackage
`default_nettype wire

// [src/fpdc_fifo.sv]
// word fifo between routine rom reads and ram writes
`default_nettype none
module fpdc_fifo
  import fpdc_pkg::*;
#(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out,
  // fill level
  output logic [$clog2(DEPTH):0] count_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("fpdc_fifo: depth must be a power of two of at least 2");

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign count_out     = wr_ptr_q - rd_ptr_q;
  assign in_ready_out  = count_out != (AW + 1)'(DEPTH);
  assign out_valid_out = count_out != '0;
  assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  // storage has no reset: contents are meaningless until written
  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + (AW + 1)'(push);
      rd_ptr_q <= rd_ptr_q + (AW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [src/fpdc_download_ctrl.sv]
// download control: routine copy into on-chip ram and result byte
`default_nettype none
module fpdc_download_ctrl
  import fpdc_pkg::*;
#(
  parameter int unsigned DEPTH          = FIFO_DEPTH,
  parameter logic [31:0] PROG_ROM_BASE  = 32'h00000000,
  parameter logic [31:0] ERASE_ROM_BASE = 32'h00000800,
  parameter bit          PROG_MAPPED    = 1'b1,
  parameter bit          ERASE_MAPPED   = 1'b1
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // interface register writes
  input  wire logic        key_wr_in,
  input  wire logic [7:0]  key_wdata_in,
  input  wire logic        dest_wr_in,
  input  wire logic [7:0]  dest_wdata_in,
  input  wire logic        prog_sel_wr_in,
  input  wire logic        prog_sel_wdata_in,
  input  wire logic        erase_sel_wr_in,
  input  wire logic        erase_sel_wdata_in,
  input  wire logic        start_wr_in,
  input  wire logic        start_wdata_in,
  // interface register state
  output logic [7:0]       key_code_register_out,
  output logic [7:0]       download_dest_select_out,
  output logic             program_routine_select_out,
  output logic             erase_routine_select_out,
  output logic             download_start_bit_out,
  output logic             busy_out,
  // routine rom, one cycle read latency
  output logic             rom_rd_out,
  output logic [31:0]      rom_addr_out,
  input  wire logic [31:0] rom_data_in,
  // on-chip ram write port
  output logic             ram_wr_valid_out,
  input  wire logic        ram_wr_ready_in,
  output fpdc_ram_req_t    ram_req_out,
  // cpu general register protection
  input  wire logic        routine_exec_in,
  output logic [GPR_COUNT-1:0] gpr_write_mask_out
);
  if (DEPTH < 4)
    $error("fpdc_download_ctrl: fifo depth below 4 cannot cover rom latency");

  localparam int unsigned CW = $clog2(DEPTH);

  fpdc_state_t       state_q, state_d;
  logic [7:0]        key_q;
  logic [7:0]        dest_q;
  logic              prog_sel_q;
  logic              erase_sel_q;
  logic              start_q;
  logic [WORD_CNT_W-1:0] rd_cnt_q;
  logic [WORD_CNT_W-1:0] wr_cnt_q;
  logic              rom_pend_q;
  logic [7:0]        result_q;
  logic [31:0]       win_base_q;
  logic [31:0]       src_base_q;

  // fifo wiring
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [31:0]       fifo_out_data;
  logic [CW:0]       fifo_count;

  // start write decode and checks
  wire start_take   = start_wr_in && start_wdata_in && key_q == KEY_DOWNLOAD
                      && state_q == ST_IDLE;
  wire dest_bad     = dest_q[6:0] > DEST_MAX_VALID;
  wire sel_bad      = (prog_sel_q == erase_sel_q)
                      || (prog_sel_q && !PROG_MAPPED)
                      || (erase_sel_q && !ERASE_MAPPED);
  wire key_bad      = key_q != KEY_DOWNLOAD;
  wire any_bad      = sel_bad || key_bad;
  wire [7:0] result_d = {5'h00, sel_bad, key_bad, any_bad};
  wire in_check     = state_q == ST_CHECK;
  wire in_copy      = state_q == ST_COPY;
  wire in_result    = state_q == ST_RESULT;
  wire dest_err_set = in_check && dest_bad;
  wire copy_done    = in_check && !dest_bad && any_bad
                      || in_copy && wr_cnt_q == WORD_CNT_W'(ROUTINE_WORDS);
  wire sel_clear    = in_copy && wr_cnt_q == WORD_CNT_W'(ROUTINE_WORDS);

  // rom issue: room for the word already in flight keeps the fifo honest
  wire rd_more      = rd_cnt_q != WORD_CNT_W'(ROUTINE_WORDS);
  wire fifo_room    = fifo_count < (CW + 1)'(DEPTH - 1);
  wire rom_issue    = in_copy && rd_more && fifo_room && fifo_in_ready;
  wire ram_push     = in_copy && fifo_out_valid;
  wire word_taken   = ram_push && ram_wr_ready_in;
  wire result_taken = in_result && ram_wr_ready_in;

  // next state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:   if (start_take) state_d = ST_CHECK;
      ST_CHECK:  state_d = dest_bad ? ST_DONE : (any_bad ? ST_RESULT : ST_COPY);
      ST_COPY:   if (copy_done) state_d = ST_RESULT;
      ST_RESULT: if (ram_wr_ready_in) state_d = ST_DONE;
      ST_DONE:   state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // software registers; hardware set of the error bit wins over a write
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key_q       <= KEY_RESET;
      dest_q      <= DEST_RESET;
      prog_sel_q  <= 1'b0;
      erase_sel_q <= 1'b0;
    end
    else
    begin
      if (key_wr_in)
        key_q <= key_wdata_in;
      if (dest_wr_in && !busy_out)
        dest_q <= dest_wdata_in;
      if (dest_err_set)
        dest_q[DEST_ERR_BIT] <= 1'b1;
      if (sel_clear)
        prog_sel_q <= 1'b0;
      else if (prog_sel_wr_in && !busy_out)
        prog_sel_q <= prog_sel_wdata_in;
      if (sel_clear)
        erase_sel_q <= 1'b0;
      else if (erase_sel_wr_in && !busy_out)
        erase_sel_q <= erase_sel_wdata_in;
    end
  end

  // start bit stands for the whole download
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      start_q <= 1'b0;
    else if (start_take)
      start_q <= 1'b1;
    else if (state_q == ST_DONE)
      start_q <= 1'b0;
  end

  // window, source and result latched in the check state, whatever the checks find
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      win_base_q <= RAM_BASE_ADDR;
      src_base_q <= PROG_ROM_BASE;
      result_q   <= 8'h00;
    end
    else if (in_check)
    begin
      win_base_q <= RAM_BASE_ADDR + WINDOW_STEP * {25'h0, dest_q[6:0]};
      src_base_q <= prog_sel_q ? PROG_ROM_BASE : ERASE_ROM_BASE;
      result_q   <= result_d;
    end
  end

  // copy counters
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_cnt_q   <= '0;
      wr_cnt_q   <= '0;
      rom_pend_q <= 1'b0;
    end
    else
    begin
      rom_pend_q <= rom_issue;
      if (in_check)
      begin
        rd_cnt_q <= '0;
        wr_cnt_q <= '0;
      end
      else
      begin
        rd_cnt_q <= rd_cnt_q + WORD_CNT_W'(rom_issue);
        wr_cnt_q <= wr_cnt_q + WORD_CNT_W'(word_taken);
      end
    end
  end

  fpdc_fifo #(
    .WIDTH (32),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (rom_pend_q),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (rom_data_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (ram_wr_ready_in && in_copy),
    .out_data_out  (fifo_out_data),
    .count_out     (fifo_count)
  );

  // ram write: routine words, then the result byte at the window start
  wire [31:0] copy_addr = win_base_q + {20'h0, wr_cnt_q, 2'b00};
  assign ram_wr_valid_out     = ram_push || in_result;
  assign ram_req_out.addr     = in_result ? win_base_q : copy_addr;
  assign ram_req_out.data     = in_result ? {result_q, 24'h000000} : fifo_out_data;
  assign ram_req_out.byte_en  = in_result ? BE_FIRST_BYTE : BE_WORD;

  assign rom_rd_out   = rom_issue;
  assign rom_addr_out = src_base_q + {20'h0, rd_cnt_q, 2'b00};

  // register state out
  assign key_code_register_out      = key_q;
  assign download_dest_select_out   = dest_q;
  assign program_routine_select_out = prog_sel_q;
  assign erase_routine_select_out   = erase_sel_q;
  assign download_start_bit_out     = start_q;
  assign busy_out                   = state_q != ST_IDLE;

  // gprs: none writable during download, only the result one while a routine runs
  // r4/r5 carry inputs and are never written back
  assign gpr_write_mask_out = busy_out ? '0
                            : (routine_exec_in ? (GPR_COUNT'(1) << GPR_RESULT) : '0);
  // result byte resets to 00; gpr parameters are never initialised by reset
  // completion is seen by the start bit clearing, after the result write when the destination is in range; preload and stack stay with software

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  start_key_gate_a: assert property (start_take |-> key_q == KEY_DOWNLOAD)
    else $error("start taken without download key");
  no_start_badkey_a: assert property (state_q == ST_IDLE && key_q != KEY_DOWNLOAD
                                      |=> state_q == ST_IDLE)
    else $error("download began without key");
  copy_starts_a: assert property (in_check && !dest_bad && !any_bad |=> in_copy ##1 rom_issue || !fifo_room)
    else $error("copy did not begin");
  copy_window_a: assert property (ram_push |-> ram_req_out.addr - win_base_q < ROUTINE_BYTES)
    else $error("copy outside 2 kbyte window");
  result_addr_a: assert property (in_result |-> ram_req_out.addr == win_base_q
                                  && ram_req_out.byte_en == BE_FIRST_BYTE)
    else $error("result not at window start");
  result_upper_a: assert property (in_result |-> ram_req_out.data[31:27] == 5'h00)
    else $error("result upper bits nonzero");
  sel_err_bit_a: assert property (in_check |=> result_q[RES_SEL_ERR_BIT] == $past(sel_bad))
    else $error("selection error bit wrong");
  key_err_bit_a: assert property (in_check |=> result_q[RES_KEY_ERR_BIT] == ($past(key_q) != KEY_DOWNLOAD))
    else $error("key error bit wrong");
  fail_bit_a: assert property (in_result |-> result_q[RES_FAIL_BIT]
                               == (result_q[RES_SEL_ERR_BIT] | result_q[RES_KEY_ERR_BIT]))
    else $error("fail bit disagrees");
  gpr_keep_a: assert property (busy_out |-> gpr_write_mask_out == '0)
    else $error("gpr writable during download");
  start_stands_a: assert property (busy_out |-> download_start_bit_out)
    else $error("start bit dropped during download");
  dest_abort_a: assert property (in_check && dest_bad |=> state_q == ST_DONE
                                 && dest_q[DEST_ERR_BIT] && !ram_wr_valid_out)
    else $error("bad destination not aborted");
  sel_autoclr_a: assert property (sel_clear |=> !prog_sel_q && !erase_sel_q)
    else $error("routine select not cleared");
  result_last_a: assert property (in_result |-> in_check == 1'b0 && $past(state_q) != ST_IDLE
                                  && (wr_cnt_q == WORD_CNT_W'(ROUTINE_WORDS) || result_q[RES_FAIL_BIT]))
    else $error("result before copy end");

  good_download_c: cover property (in_copy ##[1:1000] in_result && !result_q[RES_FAIL_BIT]);
  key_fail_c:      cover property (in_result && result_q[RES_KEY_ERR_BIT]);
  dest_abort_c:    cover property (dest_err_set);
  ram_stall_c:     cover property (ram_push && !ram_wr_ready_in && !fifo_in_ready);
endmodule
`default_nettype wire

// [tb/fpdc_cpu_model.sv]
// behavioural rom and ram-side partner for the download control block
`default_nettype none
module fpdc_cpu_model
  import fpdc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // routine rom, one cycle read latency
  input  wire logic        rom_rd_in,
  input  wire logic [31:0] rom_addr_in,
  output logic [31:0]      rom_data_out,
  // ram write port, stalls at random when slow
  input  wire logic        slow_in,
  output logic             ram_wr_ready_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // outside the read slot the data toggles so a late sample cannot pass
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rom_data_out <= 32'h0;
    else if (rom_rd_in)
      rom_data_out <= {~rom_addr_in[15:0], rom_addr_in[15:0]} ^ 32'h3c5aa5c3;
    else
      rom_data_out <= ~rom_data_out;
    ram_wr_ready_out <= !slow_in || ($urandom % 3 == 0);
  end
endmodule
`default_nettype wire

// [tb/tb_flash_program_download_control.sv]
// self-checking bench for the flash program download control block
`default_nettype none
module tb_flash_program_download_control
  import fpdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] SRC_PROG  = 32'h00000000;
  localparam logic [31:0] SRC_ERASE = 32'h00001000;

  logic clk_in = 1'b0, rst_n_in = 1'b0, slow = 1'b0, routine_exec_in = 1'b0;
  logic key_wr_in = 1'b0, dest_wr_in = 1'b0, prog_sel_wr_in = 1'b0, erase_sel_wr_in = 1'b0;
  logic start_wr_in = 1'b0, start_wdata_in = 1'b1, prog_sel_wdata_in = 1'b0, erase_sel_wdata_in = 1'b0;
  logic [7:0]    key_wdata_in = 8'h00, dest_wdata_in = 8'h00, key_code_register, download_dest_select;
  logic          program_routine_select, erase_routine_select, download_start_bit, busy;
  logic          rom_rd, ram_wr_valid, ram_wr_ready;
  logic [31:0]   rom_addr, rom_data;
  logic [15:0]   gpr_write_mask;
  fpdc_ram_req_t ram_req, got;
  fpdc_ram_req_t exp_q[$];
  int            bad_count = 0;
  int            checks = 0;
  logic [7:0]    res_mem = 8'hff;

  always #2.5 clk_in = ~clk_in;

  fpdc_download_ctrl #(.DEPTH(FIFO_DEPTH), .PROG_ROM_BASE(SRC_PROG), .ERASE_ROM_BASE(SRC_ERASE),
    .PROG_MAPPED(1'b1), .ERASE_MAPPED(1'b1)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .key_wr_in(key_wr_in), .key_wdata_in(key_wdata_in),
    .dest_wr_in(dest_wr_in), .dest_wdata_in(dest_wdata_in), .prog_sel_wr_in(prog_sel_wr_in),
    .prog_sel_wdata_in(prog_sel_wdata_in), .erase_sel_wr_in(erase_sel_wr_in),
    .erase_sel_wdata_in(erase_sel_wdata_in), .start_wr_in(start_wr_in), .start_wdata_in(start_wdata_in),
    .key_code_register_out(key_code_register), .download_dest_select_out(download_dest_select),
    .program_routine_select_out(program_routine_select), .erase_routine_select_out(erase_routine_select),
    .download_start_bit_out(download_start_bit), .busy_out(busy), .rom_rd_out(rom_rd),
    .rom_addr_out(rom_addr), .rom_data_in(rom_data), .ram_wr_valid_out(ram_wr_valid),
    .ram_wr_ready_in(ram_wr_ready), .ram_req_out(ram_req), .routine_exec_in(routine_exec_in),
    .gpr_write_mask_out(gpr_write_mask));

  fpdc_cpu_model partner_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .rom_rd_in(rom_rd), .rom_addr_in(rom_addr),
    .rom_data_out(rom_data), .slow_in(slow), .ram_wr_ready_out(ram_wr_ready));

  function automatic logic [31:0] rom_word(input logic [31:0] a);
    return {~a[15:0], a[15:0]} ^ 32'h3c5aa5c3;
  endfunction

  task chk(input logic [71:0] g, input logic [71:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t ns: got %0h expected %0h", $time, g, e);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // en bits: start, erase select, program select, destination, key
  task reg_wr(input logic [4:0] en, input logic [7:0] v);
    @(posedge clk_in);
    {start_wr_in, erase_sel_wr_in, prog_sel_wr_in, dest_wr_in, key_wr_in} <= en;
    key_wdata_in <= v;
    dest_wdata_in <= v;
    prog_sel_wdata_in <= v[0];
    erase_sel_wdata_in <= v[0];
    @(posedge clk_in);
    {start_wr_in, erase_sel_wr_in, prog_sel_wr_in, dest_wr_in, key_wr_in} <= 5'h00;
  endtask

  // one download; k is written on the start edge so the check sees it
  task run(input logic p, input logic e, input logic [7:0] d, input logic [7:0] k, input logic sm);
    logic [31:0] win;
    logic [2:0]  res;
    logic        bad_dest;
    logic        clr;
    int          n;
    win = RAM_BASE_ADDR + WINDOW_STEP * d[6:0];
    res = {!(p ^ e), k != KEY_DOWNLOAD, !(p ^ e) || k != KEY_DOWNLOAD};
    bad_dest = d[6:0] > DEST_MAX_VALID;
    clr = !bad_dest && res == 3'h0;
    n = 0;
    slow <= sm;
    reg_wr(5'h01, KEY_DOWNLOAD);
    reg_wr(5'h02, d);
    reg_wr(5'h04, {7'h0, p});
    reg_wr(5'h08, {7'h0, e});
    if (clr)
      for (int i = 0; i < ROUTINE_WORDS; i++)
        exp_q.push_back(fpdc_ram_req_t'{win + 4 * i, rom_word((e ? SRC_ERASE : SRC_PROG) + 4 * i), BE_WORD});
    if (!bad_dest)
      exp_q.push_back(fpdc_ram_req_t'{win, {5'h0, res, 24'h0}, BE_FIRST_BYTE});
    res_mem = 8'hff;
    reg_wr(5'h11, k);
    #1;
    chk({download_start_bit, busy}, 2'b11);
    // busy writes must bounce, destination and program select included
    if (!bad_dest)
      reg_wr(5'h06, 8'h02);
    do
    begin
      @(posedge clk_in);
      #1;
      n++;
    end while (busy === 1'b1 && n < 5000);
    chk(busy, 1'b0);
    chk(exp_q.size(), 0);
    chk(download_start_bit, 1'b0);
    chk(download_dest_select, {bad_dest, d[6:0]});
    chk({program_routine_select, erase_routine_select}, clr ? 2'b00 : {p, e});
    chk(res_mem, bad_dest ? 8'hff : {5'h0, res});
    $display("test done: select %b%b dest %0h key %0h", p, e, d, k);
  endtask

  // every accepted ram write is matched against the oldest note
  always @(posedge clk_in)
    if (rst_n_in && ram_wr_valid && ram_wr_ready)
    begin
      chk(gpr_write_mask, 16'h0);
      if (exp_q.size() == 0)
        chk(ram_req, 72'h0);
      else
      begin
        if (ram_req.byte_en === BE_FIRST_BYTE)
          res_mem = ram_req.data[31:24];
        got = ram_req;
        if (exp_q[0].byte_en === BE_FIRST_BYTE)
          got.data[23:0] = 24'h0;
        chk(got, exp_q.pop_front());
      end
    end

  initial
  begin
    #300000;
    bad_count++;
    summarize;
  end

  initial
  begin
    void'($urandom(22));
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    chk({key_code_register, download_dest_select, program_routine_select, erase_routine_select,
      download_start_bit, busy, gpr_write_mask}, 0);
    run(1'b1, 1'b0, 8'h00, KEY_DOWNLOAD, 1'b0);
    run(1'b0, 1'b1, 8'h05, KEY_DOWNLOAD, 1'b1);
    run(1'b1, 1'b0, 8'($urandom % 6), KEY_DOWNLOAD, 1'b1);
    run(1'b1, 1'b1, 8'h03, KEY_DOWNLOAD, 1'b1);
    run(1'b0, 1'b0, 8'h01, KEY_DOWNLOAD, 1'b0);
    run(1'b1, 1'b0, 8'h02, 8'h3c, 1'b1);
    run(1'b1, 1'b1, 8'h04, 8'($urandom % 8'ha5), 1'b0);
    run(1'b1, 1'b0, 8'h06, KEY_DOWNLOAD, 1'b0);
    run(1'b0, 1'b1, 8'h7f, KEY_DOWNLOAD, 1'b0);
    reg_wr(5'h01, 8'h5a);
    reg_wr(5'h10, 8'h00);
    #1;
    chk({download_start_bit, busy, key_code_register}, {2'b00, 8'h5a});
    reg_wr(5'h01, KEY_DOWNLOAD);
    start_wdata_in <= 1'b0;
    reg_wr(5'h10, 8'h00);
    #1;
    chk({download_start_bit, busy}, 2'b00);
    @(posedge clk_in);
    routine_exec_in <= 1'b1; // stack saving stays with software
    @(posedge clk_in);
    #1;
    chk(gpr_write_mask, 16'h0001);
    $display("test done: refused start and routine register guard");
    summarize;
  end
endmodule
`default_nettype wire
